// ==== hw/lcd_frame_pkg.sv ====
// Summary of operation
// R1 - static duty: each segment own terminal, driven against single common line
// R2 - two commons: multiplexed waveform, half or one-third bias selectable
// R3 - software picks one-third bias for three or four commons
// R4 - low-power select bit swaps in reduced-toggle waveform on all pins
// R5 - low-power mode: latch data and raise flag every second frame only
// R6 - synchronous clock: display runs in idle and power-save sleep
// R7 - async clock with RC system clock: runs in idle, ADC-noise, power-save
// R8 - external clock enable plus async source enables timer pin input buffer
// R9 - software disables controller before deep sleep with synchronous clock
// R10 - blanking: finish current frame, then all pins to ground, memory kept
// R11 - software blanks display before disabling controller
// R12 - port mask frees unused segment pins; unused commons return to port
// R13 - software sets rate, duty, bias, mask before enable; contrast anytime
// R14 - software disables controller before reconfiguring
// R15 - memory, blanking, waveform, contrast latched just before each frame
// R16 - writes accepted anytime; an update may straddle a frame latch
// R17 - software updates from frame-start handler right after the latch
// R18 - frame flag set at frame start with the latch; write one clears
// R19 - two-bit common count selects static, 1/2, 1/3, 1/4 duty
// R20 - commons addressed in order from first, each with its latched row
// R21 - enable written zero stops drive at once, pins back to ports
// R22 - each frame or frame pair averages zero volts across every segment
package lcd_frame_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int SEG_MAX  = 40;
  localparam int COM_MAX  = 4;
  localparam int DM_WORDS = 20;  // five bytes per common line
  localparam int DM_PER_COM = 5;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_CTRL_A   = 12'h000;
  localparam logic [11:0] OFS_CFG_B    = 12'h004;
  localparam logic [11:0] OFS_FRATE    = 12'h008;
  localparam logic [11:0] OFS_CONTRAST = 12'h00C;
  localparam logic [11:0] OFS_ASYNC    = 12'h010;
  localparam logic [11:0] OFS_STATUS   = 12'h014;
  localparam logic [11:0] OFS_DMEM     = 12'h040;
  localparam logic [11:0] OFS_DMEM_END = 12'h08C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int B_ENABLE   = 7;
  localparam int B_LOWPOWER = 6;
  localparam int B_FLAG     = 4;
  localparam int B_IRQ_EN   = 3;
  localparam int B_BLANK    = 0;
  localparam int B_CLK_SRC  = 7;
  localparam int B_HALFBIAS = 6;
  localparam int B_MUX_LO   = 4;
  localparam int B_PRESC_LO = 4;
  localparam int B_EXT_CLK  = 6;
  localparam int B_ST_RUN   = 7;
  localparam int B_ST_BLANK = 6;
  localparam int B_ST_LP    = 5;
  localparam int B_ST_COM   = 0;

  // ****************************************
  // sleep modes and pin level codes
  // ****************************************
  localparam logic [2:0] SLP_ACTIVE  = 3'h0;
  localparam logic [2:0] SLP_IDLE    = 3'h1;
  localparam logic [2:0] SLP_ADC     = 3'h2;
  localparam logic [2:0] SLP_PSAVE   = 3'h3;
  localparam logic [1:0] LV_GND  = 2'h0;  // ground
  localparam logic [1:0] LV_LOW  = 2'h1;  // 1/3, or mid level in half bias
  localparam logic [1:0] LV_HIGH = 2'h2;  // 2/3
  localparam logic [1:0] LV_TOP  = 2'h3;  // full contrast voltage

  // ****************************************
  // lookup tables
  // ****************************************
  // last count of the ripple prescaler: divide by 16 .. 4096
  localparam logic [11:0] PRESC_LAST [8] = '{12'h00F, 12'h03F, 12'h07F, 12'h0FF,
                                             12'h1FF, 12'h3FF, 12'h7FF, 12'hFFF};
  // segment pins owned by the display per port mask code
  localparam logic [5:0] SEG_USED [16] = '{6'h0D, 6'h0F, 6'h11, 6'h13, 6'h15, 6'h17,
                                           6'h18, 6'h19, 6'h1B, 6'h1D, 6'h1F, 6'h21,
                                           6'h23, 6'h25, 6'h27, 6'h28};

  typedef enum logic {ST_OFF, ST_RUN} seq_state_t;

endpackage

// ==== hw/lcd_tick_gen.sv ====
`timescale 1ns/1ps
// ****************************************
// prescaler and fine divider for the frame timing
// ****************************************
module lcd_tick_gen
  import lcd_frame_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  // control
  input  wire logic       i_run,
  input  wire logic       i_src_pulse,
  input  wire logic [2:0] i_presc_sel,
  input  wire logic [2:0] i_div_sel,
  // timing output
  output logic            o_tick
);

  logic [11:0] presc_q;
  logic [2:0]  div_q;
  logic        presc_wrap;

  assign presc_wrap = i_src_pulse && (presc_q == PRESC_LAST[i_presc_sel]);

  // ripple prescaler; held clear while stopped so each frame starts aligned
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_run) begin
      presc_q <= 12'h000;
    end else if (presc_wrap) begin
      presc_q <= 12'h000;
    end else if (i_src_pulse) begin
      presc_q <= presc_q + 12'h001;
    end
  end

  // divide by 1 to 8 after the prescaler
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_run) begin
      div_q  <= 3'h0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= presc_wrap && (div_q == i_div_sel);
      if (presc_wrap) begin
        div_q <= (div_q == i_div_sel) ? 3'h0 : div_q + 3'h1;
      end
    end
  end

endmodule

// ==== hw/lcd_frame_ctrl.sv ====
`timescale 1ns/1ps
// ****************************************
// segment display frame control with APB register file
// ****************************************
module lcd_frame_ctrl
  import lcd_frame_pkg::*;
(
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_srst,
  // apb slave
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [11:0]            i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // clock sources and power state
  input  wire logic                   i_timer_osc_pin_one,
  input  wire logic                   i_sys_clk_is_rc,
  input  wire logic [2:0]             i_sleep_mode,
  output logic                        o_ext_clock_buf_en,
  // pin drive towards the glass
  output logic [2*SEG_MAX-1:0]        o_seg_level,
  output logic [2*COM_MAX-1:0]        o_com_level,
  output logic [SEG_MAX-1:0]          o_seg_drive_en,
  output logic [COM_MAX-1:0]          o_com_drive_en,
  output logic                        o_half_bias,
  output logic [7:0]                  o_contrast
);

  // ****************************************
  // software visible registers
  // ****************************************
  logic       controller_enable_q;
  logic       low_power_waveform_sel_q;
  logic       frame_start_flag_q;
  logic       frame_irq_enable_q;
  logic       display_blank_q;
  logic       lcd_clock_source_sel_q;
  logic       half_bias_select_q;
  logic [1:0] common_count_select_q;
  logic [3:0] segment_port_mask_q;
  logic [2:0] presc_sel_q;
  logic [2:0] frame_clock_divide_q;
  logic [7:0] contrast_control_reg_q;
  logic       ext_clock_input_en_q;
  logic [7:0] display_memory_word_q [DM_WORDS];

  // ****************************************
  // frame sequencer and latches
  // ****************************************
  seq_state_t                    state_q;
  logic [1:0]                    com_q;
  logic                          half_q;
  logic                          pair_q;
  logic                          osc_prev_q;
  logic                          pulse_prev_q;
  logic [DM_WORDS*8-1:0]         lat_mem_q;
  logic                          lat_blank_q;
  logic                          lat_lp_q;

  logic        wr_en;
  logic        acc;
  logic        mapped;
  logic        is_dmem;
  logic [4:0]  dm_idx;
  logic [7:0]  rd_byte;
  logic        tick;
  logic        src_pulse;
  logic        clk_run;
  logic        frame_end;
  logic        frame_start;
  logic        latch_now;
  logic        phase;
  logic [SEG_MAX-1:0] row;

  // ****************************************
  // apb decode
  // ****************************************
  // one wait state so read data and pready both come from flops
  assign acc     = i_psel && i_penable;
  assign wr_en   = acc && o_pready && i_pwrite && !o_pslverr;
  assign is_dmem = (i_paddr >= OFS_DMEM) && (i_paddr <= OFS_DMEM_END);
  assign dm_idx  = 5'((i_paddr - OFS_DMEM) >> 2);
  assign mapped  = (i_paddr[1:0] == 2'h0) && (is_dmem || i_paddr == OFS_CTRL_A
                   || i_paddr == OFS_CFG_B || i_paddr == OFS_FRATE
                   || i_paddr == OFS_CONTRAST || i_paddr == OFS_ASYNC
                   || i_paddr == OFS_STATUS);

  // read mux; reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (is_dmem) begin
      rd_byte = display_memory_word_q[dm_idx];
    end else begin
      case (i_paddr)
        OFS_CTRL_A: begin
          rd_byte[B_ENABLE]   = controller_enable_q;
          rd_byte[B_LOWPOWER] = low_power_waveform_sel_q;
          rd_byte[B_FLAG]     = frame_start_flag_q;
          rd_byte[B_IRQ_EN]   = frame_irq_enable_q;
          rd_byte[B_BLANK]    = display_blank_q;
        end
        OFS_CFG_B: begin
          rd_byte = {lcd_clock_source_sel_q, half_bias_select_q,
                     common_count_select_q, segment_port_mask_q};
        end
        OFS_FRATE:    rd_byte = {1'b0, presc_sel_q, 1'b0, frame_clock_divide_q};
        OFS_CONTRAST: rd_byte = contrast_control_reg_q;
        OFS_ASYNC:    rd_byte[B_EXT_CLK] = ext_clock_input_en_q;
        OFS_STATUS: begin
          rd_byte[B_ST_RUN]       = (state_q == ST_RUN);
          rd_byte[B_ST_BLANK]     = lat_blank_q;
          rd_byte[B_ST_LP]        = lat_lp_q;
          rd_byte[B_ST_COM +: 2]  = com_q;
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // handshake and read data
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc && !o_pready;
      o_pslverr <= acc && !o_pready && !mapped;
      if (acc && !o_pready) begin
        o_prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // writes land at any time; latching decides when blank, low-power and contrast show (R16)
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      controller_enable_q      <= 1'b0;
      low_power_waveform_sel_q <= 1'b0;
      frame_irq_enable_q       <= 1'b0;
      display_blank_q          <= 1'b0;
      lcd_clock_source_sel_q   <= 1'b0;
      half_bias_select_q       <= 1'b0;
      common_count_select_q    <= 2'h0;
      segment_port_mask_q      <= 4'h0;
      presc_sel_q              <= 3'h0;
      frame_clock_divide_q     <= 3'h0;
      contrast_control_reg_q   <= 8'h00;
      ext_clock_input_en_q     <= 1'b0;
    end else if (wr_en) begin
      case (i_paddr)
        OFS_CTRL_A: begin
          controller_enable_q      <= i_pwdata[B_ENABLE];
          low_power_waveform_sel_q <= i_pwdata[B_LOWPOWER];
          frame_irq_enable_q       <= i_pwdata[B_IRQ_EN];
          display_blank_q          <= i_pwdata[B_BLANK];
        end
        OFS_CFG_B: begin
          lcd_clock_source_sel_q <= i_pwdata[B_CLK_SRC];
          half_bias_select_q     <= i_pwdata[B_HALFBIAS];
          common_count_select_q  <= i_pwdata[B_MUX_LO +: 2];
          segment_port_mask_q    <= i_pwdata[3:0];
        end
        OFS_FRATE: begin
          presc_sel_q          <= i_pwdata[B_PRESC_LO +: 3];
          frame_clock_divide_q <= i_pwdata[2:0];
        end
        OFS_CONTRAST: contrast_control_reg_q <= i_pwdata[7:0];
        OFS_ASYNC:    ext_clock_input_en_q   <= i_pwdata[B_EXT_CLK];
        default: ;
      endcase
    end
  end

  // display memory words
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < DM_WORDS; i++) begin
        display_memory_word_q[i] <= 8'h00;
      end
    end else if (wr_en && is_dmem) begin
      display_memory_word_q[dm_idx] <= i_pwdata[7:0];
    end
  end

  // frame flag: hardware set wins over a write-one clear
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      frame_start_flag_q <= 1'b0;
    end else if (latch_now) begin
      frame_start_flag_q <= 1'b1;  // R18
    end else if (wr_en && i_paddr == OFS_CTRL_A && i_pwdata[B_FLAG]) begin
      frame_start_flag_q <= 1'b0;  // R18
    end
  end

  // ****************************************
  // clock source and sleep behaviour
  // ****************************************
  // the timer pin is taken as synchronous, so a plain edge detect suffices
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= i_timer_osc_pin_one;
    end
  end

  assign src_pulse = lcd_clock_source_sel_q ? (i_timer_osc_pin_one && !osc_prev_q) : 1'b1;

  // lcd clock pulse of the previous cycle; the prescaler stays clear until
  // one has passed, so the first tick is a whole lcd period away
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pulse_prev_q <= 1'b0;
    end else begin
      pulse_prev_q <= src_pulse;
    end
  end

  // sync source lives through idle and power-save only; async with RC
  // system clock also survives ADC noise reduction
  always_comb begin
    case (i_sleep_mode)
      SLP_ACTIVE: clk_run = 1'b1;
      SLP_IDLE:   clk_run = 1'b1;          // R6 R7
      SLP_PSAVE:  clk_run = 1'b1;          // R6 R7
      SLP_ADC:    clk_run = lcd_clock_source_sel_q && i_sys_clk_is_rc;  // R7
      default:    clk_run = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_ext_clock_buf_en <= 1'b0;
    end else begin
      o_ext_clock_buf_en <= ext_clock_input_en_q && lcd_clock_source_sel_q;  // R8
    end
  end

  lcd_tick_gen u_tick (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_run       (controller_enable_q && clk_run && (pulse_prev_q || state_q == ST_RUN)),
    .i_src_pulse (src_pulse),
    .i_presc_sel (presc_sel_q),
    .i_div_sel   (frame_clock_divide_q),
    .o_tick      (tick)
  );

  // ****************************************
  // frame sequencer
  // ****************************************
  // each common gets two half phases, of opposite polarity in the default waveform
  assign frame_end   = tick && half_q && (com_q == common_count_select_q);
  assign frame_start = ((state_q == ST_OFF) && controller_enable_q && pulse_prev_q) || frame_end;
  // low-power: one latch per frame pair, pair_q marks the first frame
  assign latch_now   = frame_start && (!lat_lp_q || !pair_q || state_q == ST_OFF);  // R5

  always_ff @(posedge i_mclk) begin
    if (i_srst || !controller_enable_q) begin
      state_q <= ST_OFF;                   // R21
      com_q   <= 2'h0;
      half_q  <= 1'b0;
      pair_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_OFF: begin
          // start just after an lcd clock so the first half phase is full length (R22)
          if (pulse_prev_q) begin
            state_q <= ST_RUN;
            pair_q  <= 1'b1;
          end
        end
        ST_RUN: begin
          if (tick) begin
            half_q <= !half_q;
            if (half_q) begin
              com_q <= (com_q == common_count_select_q) ? 2'h0 : com_q + 2'h1;  // R19 R20
            end
          end
          if (frame_start) begin
            pair_q <= latch_now;           // R5
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // latch memory and latched controls just before a frame begins
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      lat_mem_q   <= '0;
      lat_blank_q <= 1'b0;
      lat_lp_q    <= 1'b0;
      o_contrast  <= 8'h00;
    end else if (latch_now) begin
      for (int i = 0; i < DM_WORDS; i++) begin
        lat_mem_q[i*8 +: 8] <= display_memory_word_q[i];  // R15
      end
      lat_blank_q <= display_blank_q;      // R10 R15
      lat_lp_q    <= low_power_waveform_sel_q;  // R4 R15
      o_contrast  <= contrast_control_reg_q;    // R15
    end
  end

  // ****************************************
  // output decoder
  // ****************************************
  // default waveform flips every half phase; low-power flips per frame,
  // so the pair of frames cancels out instead
  assign phase = lat_lp_q ? !pair_q : half_q;  // R4 R22
  assign row   = lat_mem_q[int'(com_q) * SEG_MAX +: SEG_MAX];  // R20

  generate
    for (genvar s = 0; s < SEG_MAX; s++) begin : g_seg
      always_ff @(posedge i_mclk) begin
        if (i_srst || state_q == ST_OFF) begin
          o_seg_level[2*s +: 2] <= LV_GND;
          o_seg_drive_en[s]     <= 1'b0;  // R21
        end else begin
          o_seg_drive_en[s] <= (6'(s) < SEG_USED[segment_port_mask_q]);  // R12
          if (lat_blank_q) begin
            o_seg_level[2*s +: 2] <= LV_GND;  // R10
          end else if (row[s]) begin
            o_seg_level[2*s +: 2] <= phase ? LV_GND : LV_TOP;  // R1 R22
          end else if (common_count_select_q == 2'h0) begin
            o_seg_level[2*s +: 2] <= phase ? LV_TOP : LV_GND;  // R1
          end else if (half_bias_select_q) begin
            o_seg_level[2*s +: 2] <= LV_LOW;  // R2
          end else begin
            o_seg_level[2*s +: 2] <= phase ? LV_HIGH : LV_LOW;  // R2
          end
        end
      end
    end

    for (genvar c = 0; c < COM_MAX; c++) begin : g_com
      always_ff @(posedge i_mclk) begin
        if (i_srst || state_q == ST_OFF) begin
          o_com_level[2*c +: 2] <= LV_GND;
          o_com_drive_en[c]     <= 1'b0;  // R21
        end else begin
          o_com_drive_en[c] <= (2'(c) <= common_count_select_q);  // R12 R19
          if (lat_blank_q) begin
            o_com_level[2*c +: 2] <= LV_GND;  // R10
          end else if (2'(c) > common_count_select_q) begin
            o_com_level[2*c +: 2] <= LV_GND;  // R12
          end else if (2'(c) == com_q) begin
            o_com_level[2*c +: 2] <= phase ? LV_TOP : LV_GND;  // R20
          end else if (half_bias_select_q) begin
            o_com_level[2*c +: 2] <= LV_LOW;  // R2
          end else begin
            o_com_level[2*c +: 2] <= phase ? LV_LOW : LV_HIGH;  // R2
          end
        end
      end
    end
  endgenerate

  // bias choice goes to the analog level generator
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_half_bias <= 1'b0;
    end else begin
      o_half_bias <= half_bias_select_q && (common_count_select_q != 2'h0);  // R2
    end
  end

endmodule

// ==== verif/lcd_frame_ctrl_props.sv ====
`timescale 1ns/1ps
// ****
// port checks for the frame controller
// ****
module lcd_frame_ctrl_props (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_srst,
  // apb handshake
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // glass pins
  input wire logic [79:0] o_seg_level,
  input wire logic [7:0]  o_com_level,
  input wire logic [3:0]  o_com_drive_en,
  input wire logic        o_half_bias
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // exactly one wait state, ready lasts one cycle
  apb_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("ready late");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  // commons are always a run from the first line
  com_prefix_a: assert property ((o_com_drive_en & (o_com_drive_en + 4'h1)) == 4'h0)
    else $error("common enables not contiguous");
  // a stopped display leaves every pin at ground
  idle_ground_a: assert property (!o_com_drive_en[0] |-> !(|o_seg_level) && !(|o_com_level))
    else $error("levels while off");
  unused_com_a: assert property (!o_com_drive_en[3] |-> o_com_level[7:6] == 2'h0)
    else $error("unused common driven");
  static_drive_a: assert property (o_com_drive_en == 4'h1 |->
    !o_half_bias && o_com_level[1:0] inside {2'h0, 2'h3})
    else $error("static common level");
  // half bias has no two-thirds level on commons
  half_lvl_a: assert property (o_half_bias |-> o_com_level[1:0] != 2'h2 &&
    o_com_level[3:2] != 2'h2 && o_com_level[5:4] != 2'h2 && o_com_level[7:6] != 2'h2)
    else $error("bad half bias level");
  // each phase stands at least eight clocks, half the shortest tick of sixteen
  level_hold_a: assert property (o_com_drive_en[0] && $changed(o_com_level) |=>
    ($stable(o_com_level) || !o_com_drive_en[0])[*8])
    else $error("phase too short");
endmodule

bind lcd_frame_ctrl lcd_frame_ctrl_props u_props (.i_mclk, .i_srst, .i_psel, .i_penable,
  .o_pready, .o_pslverr, .o_seg_level, .o_com_level, .o_com_drive_en, .o_half_bias);

// ==== verif/lcd_glass_model.sv ====
`timescale 1ns/1ps
// ****
// passive glass: net charge on segment 0 against each common
// ****
module lcd_glass_model (
  // clock
  input  wire logic        i_mclk,
  // pins from the controller
  input  wire logic [79:0] i_seg_level,
  input  wire logic [7:0]  i_com_level,
  input  wire logic [39:0] i_seg_en,
  input  wire logic [3:0]  i_com_en,
  input  wire logic        i_half_bias,
  // summed voltage in sixths of full scale
  output int               o_dc [4]
);
  // half bias mid level is half scale, not one third
  function automatic int volts(logic [1:0] lv);
    return (lv == 2'h1 && i_half_bias) ? 3 : 2 * lv;
  endfunction
  initial o_dc = '{0, 0, 0, 0};
  // charge builds only while both electrodes are driven
  always @(posedge i_mclk) begin
    for (int c = 0; c < 4; c++) begin
      if (i_seg_en[0] && i_com_en[c]) begin
        o_dc[c] <= o_dc[c] + volts(i_seg_level[1:0]) - volts(i_com_level[2*c +: 2]);
      end
    end
  end
endmodule

// ==== verif/segment_lcd_frame_control_tb_top.sv ====
`timescale 1ns/1ps
module segment_lcd_frame_control_tb_top;
  import lcd_frame_pkg::*;
  logic                 i_mclk, i_srst, i_psel, i_penable, i_pwrite, err;
  logic                 i_timer_osc_pin_one, i_sys_clk_is_rc;
  logic [11:0]          i_paddr;
  logic [31:0]          i_pwdata, o_prdata, rd, ctl;
  logic                 o_pready, o_pslverr, o_ext_clock_buf_en, o_half_bias;
  logic [2:0]           i_sleep_mode;
  logic [2*SEG_MAX-1:0] o_seg_level;
  logic [2*COM_MAX-1:0] o_com_level;
  logic [SEG_MAX-1:0]   o_seg_drive_en;
  logic [COM_MAX-1:0]   o_com_drive_en;
  logic [7:0]           o_contrast;
  int                   dc [4];
  int                   n_fail = 0, checks = 0, cyc = 0, seed = 32'h289d;
  logic [11:0]          ra [5] = '{OFS_CTRL_A, OFS_CFG_B, OFS_STATUS, 12'h030, 12'h002};
  logic [2:0]           slp [7] = '{3'h0, 3'h1, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3};

  lcd_frame_ctrl DUT (.i_mclk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_timer_osc_pin_one, .i_sys_clk_is_rc,
    .i_sleep_mode, .o_ext_clock_buf_en, .o_seg_level, .o_com_level, .o_seg_drive_en,
    .o_com_drive_en, .o_half_bias, .o_contrast);
  lcd_glass_model glass (.i_mclk, .i_seg_level(o_seg_level), .i_com_level(o_com_level),
    .i_seg_en(o_seg_drive_en), .i_com_en(o_com_drive_en), .i_half_bias(o_half_bias),
    .o_dc(dc));

  // ****
  // clock, cycle count and a crystal on the timer pin
  // ****
  initial begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc[0]) i_timer_osc_pin_one <= ~i_timer_osc_pin_one;
  end

  // ****
  // helpers
  // ****
  task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; waits for ready instead of assuming a latency
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk) i_penable <= 1;
    do @(posedge i_mclk); while (o_pready !== 1'b1 && ++n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_mclk);  // idle cycle: the next setup never re-drives psel in this step
    if (n >= 20) chk("pready", 0, 1);
  endtask
  // poll the frame flag, then clear it by writing one
  task automatic wait_frame();
    int n;
    n = 0;
    do apb(0, OFS_CTRL_A, 0); while (rd[B_FLAG] !== 1'b1 && ++n < 300);
    chk("frame_flag", rd[B_FLAG], 1);
    apb(1, OFS_CTRL_A, ctl | 32'h10);
    apb(0, OFS_CTRL_A, 0);
    chk("flag_clear", rd[B_FLAG], 0);
  endtask
  function automatic logic [39:0] seg_mask(logic [3:0] pm);
    int n [16] = '{13, 15, 17, 19, 21, 23, 24, 25, 27, 29, 31, 33, 35, 37, 39, 40};
    return (40'h1 << n[pm]) - 40'h1;
  endfunction
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_mclk);
    n_fail++;
    complete_run();
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [1:0] mux;
    logic       lp, hb, asy;
    logic [3:0] pm;
    logic [7:0] con, dm;
    int         per, t0;
    {i_srst, i_psel, i_penable, i_pwrite, i_timer_osc_pin_one, i_sys_clk_is_rc} = 6'h20;
    {i_paddr, i_pwdata, i_sleep_mode, ctl} = '0;
    repeat (6) @(posedge i_mclk);
    i_srst <= 0;
    @(posedge i_mclk);
    // reset values, then unmapped and misaligned places
    for (int i = 0; i < 5; i++) begin
      apb(0, ra[i], 0);
      chk("reset_read", rd, 0);
      chk("slverr", err, i > 2);
    end
    // external clock buffer needs both the enable and the async source
    for (int k = 0; k < 4; k++) begin
      apb(1, OFS_CFG_B, k[0] << B_CLK_SRC);
      apb(1, OFS_ASYNC, k[1] << B_EXT_CLK);
      @(posedge i_mclk);
      chk("ext_buf", o_ext_clock_buf_en, k == 3);
    end
    for (int k = 0; k < 7; k++) begin
      mux = 2'(k % 4);
      asy = k > 3;
      lp = 1'($random(seed));
      hb = (mux == 2'h1) && 1'($random(seed));
      pm = 4'($random(seed));
      con = 8'($random(seed));
      dm = 8'($random(seed));
      dm[1:0] = 2'h1;
      // configure while stopped, then enable
      apb(1, OFS_CFG_B, {24'h0, asy, hb, mux, pm});
      apb(1, OFS_FRATE, 0);
      apb(1, OFS_CONTRAST, con);
      apb(1, OFS_DMEM, dm);
      i_sys_clk_is_rc <= asy;
      i_sleep_mode <= slp[k];
      ctl = {24'h0, 1'b1, lp, 6'h00};
      apb(1, OFS_CTRL_A, ctl);
      wait_frame();
      t0 = cyc;
      chk("com_en", o_com_drive_en, (2 << mux) - 1);
      chk("seg_en", o_seg_drive_en, seg_mask(pm));
      chk("contrast", o_contrast, con);
      chk("half_bias", o_half_bias, hb);
      if (mux == 2'h0) chk("static_on", o_seg_level[1:0] ^ o_com_level[1:0], 3);
      if (mux == 2'h0) chk("static_off", o_seg_level[3:2], o_com_level[1:0]);
      apb(0, OFS_STATUS, 0);
      chk("lp_latched", rd[B_ST_LP], lp);
      con = con ^ 8'($random(seed) | 1);
      apb(1, OFS_CONTRAST, con);
      chk("contrast_hold", o_contrast !== con, 1);
      wait_frame();
      per = (lp + 1) * 2 * (mux + 1) * 16 * (asy ? 4 : 1);
      chk("frame_gap", cyc - t0 > per - 8 && cyc - t0 < per + 8, 1);
      chk("contrast_new", o_contrast, con);
      ctl[B_BLANK] = 1'b1;
      apb(1, OFS_CTRL_A, ctl | 32'h10);
      wait_frame();
      wait_frame();
      chk("blank_seg", |o_seg_level, 0);
      chk("blank_com", |o_com_level, 0);
      apb(0, OFS_DMEM, 0);
      chk("dmem_kept", rd, dm);
      for (int c = 0; c < 4; c++) chk("dc", dc[c], 0);
      ctl = 0;
      apb(1, OFS_CTRL_A, 0);
      repeat (2) @(posedge i_mclk);
      chk("off_com", o_com_drive_en, 0);
      chk("off_seg", |o_seg_drive_en, 0);
      i_sleep_mode <= 3'h0;
    end
    complete_run();
  end
endmodule
